// ### hdl/bus_ctrl_pkg.sv
// constants and state encoding for the multiplexed bus controller
package bus_ctrl_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 4000;  // clk_i period, 250 MHz
  localparam int SYSTEM_CLOCK_OUT_HALF_PS   = 4000;  // half of the bus system clock
  // least time, rounded up, never below one cycle
  localparam int SYSTEM_CLOCK_OUT_HALF_CYC  = (SYSTEM_CLOCK_OUT_HALF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // widths and field positions
  // ---------------------------------------------------------------
  localparam int AD_W             = 32;
  localparam int BE_W             = 4;
  localparam int BE_LSB           = 0;     // byte enables ride in ad bits 3:0
  localparam int ADDR_LSB         = 4;     // word address from ad bit 4 up
  localparam int SYNC_W           = 3;     // pins passed through the synchroniser
  localparam int SYNC_ACK         = 0;
  localparam int SYNC_BREQ        = 1;
  localparam int SYNC_TRI         = 2;
  localparam logic [SYNC_W-1:0] SYNC_RST = 3'h7;  // all pin inputs rest negated

  // ---------------------------------------------------------------
  // bus cycle states, gray along idle-addr-strobe-hold
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE   = 3'h0,
    S_ADDR   = 3'h1,
    S_STROBE = 3'h3,
    S_HOLD   = 3'h2,
    S_GRANT  = 3'h6
  } bus_state_t;

endpackage : bus_ctrl_pkg

// ### hdl/pin_sync_if.sv
// carrier between the pin synchroniser and the controller
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface : pin_sync_if

// ### hdl/pin_sync.sv
// three-stage pin synchroniser, a change counts once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int            W       = 1,
  parameter logic [W-1:0]  RST_VAL = '1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  pin_sync_if.sync         port
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] clean_q;
  logic [W-1:0] clean_d;

  // s1 feeds s2 only, nothing else looks at it
  always_comb begin
    clean_d = clean_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        clean_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q    <= RST_VAL;
      s2_q    <= RST_VAL;
      s3_q    <= RST_VAL;
      clean_q <= RST_VAL;
    end else begin
      s1_q    <= port.raw;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      clean_q <= clean_d;
    end
  end

  assign port.clean = clean_q;

endmodule // pin_sync

// ### hdl/muxed_bus_transceiver_control.sv
// processor side of a multiplexed address/data bus with handover and tri-state mode
`timescale 1ns/1ps
module muxed_bus_transceiver_control (
  input  wire logic                        clk_i,
  input  wire logic                        arst_n_i,
  // core request side
  input  wire logic                        req_valid_i,
  input  wire logic                        req_write_i,
  input  wire logic                        req_burst_i,
  input  wire logic [bus_ctrl_pkg::AD_W-1:0] req_addr_i,
  input  wire logic [bus_ctrl_pkg::BE_W-1:0] req_be_i,
  input  wire logic [bus_ctrl_pkg::AD_W-1:0] req_wdata_i,
  output logic                             done_o,
  output logic [bus_ctrl_pkg::AD_W-1:0]    rdata_o,
  output logic                             core_stall_o,
  // bus pins
  input  wire logic [bus_ctrl_pkg::AD_W-1:0] ad_i,
  output logic [bus_ctrl_pkg::AD_W-1:0]    ad_o,
  output logic                             ad_oe_o,
  output logic                             ale_o,
  output logic                             rd_n_o,
  output logic                             wr_n_o,
  output logic                             burst_or_near_write_n_o,
  output logic                             data_drive_enable_n_o,
  output logic                             ctl_oe_o,
  input  wire logic                        ack_n_i,
  input  wire logic                        bus_request_n_i,
  output logic                             bus_grant_n_o,
  output logic                             bus_grant_oe_o,
  input  wire logic                        tristate_req_n_i,
  output logic                             system_clock_out_o
);

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  pin_sync_if #(.W(bus_ctrl_pkg::SYNC_W)) pins_if ();
  assign pins_if.raw = {tristate_req_n_i, bus_request_n_i, ack_n_i};

  pin_sync #(
    .W       (bus_ctrl_pkg::SYNC_W),
    .RST_VAL (bus_ctrl_pkg::SYNC_RST)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .port    (pins_if.sync)
  );

  logic ack_s;
  logic breq_s;
  logic tri_s;
  assign ack_s  = !pins_if.clean[bus_ctrl_pkg::SYNC_ACK];
  assign breq_s = !pins_if.clean[bus_ctrl_pkg::SYNC_BREQ];
  assign tri_s  = !pins_if.clean[bus_ctrl_pkg::SYNC_TRI];

  // ---------------------------------------------------------------
  // bus cycle sequencer
  // ---------------------------------------------------------------
  bus_ctrl_pkg::bus_state_t state_q, state_d;
  logic                          system_clock_out_q, system_clock_out_d;
  logic                          ack_seen_q, ack_seen_d;
  logic [bus_ctrl_pkg::AD_W-1:0] ad_q, ad_d;
  logic                          ad_oe_q, ad_oe_d;
  logic                          ale_q, ale_d;
  logic                          rd_n_q, rd_n_d;
  logic                          wr_n_q, wr_n_d;
  logic                          bwn_n_q, bwn_n_d;
  logic                          den_n_q, den_n_d;
  logic                          ctl_oe_q, ctl_oe_d;
  logic                          gnt_n_q, gnt_n_d;
  logic                          gnt_oe_q, gnt_oe_d;
  logic                          done_q, done_d;
  logic [bus_ctrl_pkg::AD_W-1:0] rdata_q, rdata_d;
  logic                          stall_q, stall_d;
  logic                          fall_ev;
  logic                          rise_ev;

  // the divided bus clock falls on the edge where system_clock_out_q is high
  assign fall_ev = system_clock_out_q;
  assign rise_ev = !system_clock_out_q;

  // address word with byte enables folded into the low bits
  function automatic logic [bus_ctrl_pkg::AD_W-1:0] addr_word(
    input logic [bus_ctrl_pkg::AD_W-1:0] a,
    input logic [bus_ctrl_pkg::BE_W-1:0] be
  );
    logic [bus_ctrl_pkg::AD_W-1:0] w;
    w = a;
    w[bus_ctrl_pkg::BE_LSB +: bus_ctrl_pkg::BE_W] = be;
    return w;
  endfunction

  always_comb begin
    state_d    = state_q;
    system_clock_out_d   = !system_clock_out_q;
    ack_seen_d = ack_seen_q;
    ad_d       = ad_q;
    ad_oe_d    = ad_oe_q;
    ale_d      = ale_q;
    rd_n_d     = rd_n_q;
    wr_n_d     = wr_n_q;
    bwn_n_d    = bwn_n_q;
    den_n_d    = den_n_q;
    ctl_oe_d   = ctl_oe_q;
    gnt_n_d    = gnt_n_q;
    gnt_oe_d   = gnt_oe_q;
    done_d     = 1'b0;
    rdata_d    = rdata_q;
    // core keeps running from its caches, stalls only when it needs the bus
    stall_d    = (state_q == bus_ctrl_pkg::S_GRANT) && req_valid_i;
    case (state_q)
      bus_ctrl_pkg::S_IDLE: begin
        // bus floats, controls drive their negated levels
        ad_oe_d  = 1'b0;
        ctl_oe_d = 1'b1;
        gnt_oe_d = 1'b1;
        if (breq_s && fall_ev) begin
          // controls are already negated, so handing over leaves them quiet
          state_d  = bus_ctrl_pkg::S_GRANT;
          ctl_oe_d = 1'b0;
          gnt_n_d  = 1'b0;
        end else if (req_valid_i && rise_ev) begin
          state_d = bus_ctrl_pkg::S_ADDR;
          ad_d    = addr_word(req_addr_i, req_be_i);
          ad_oe_d = 1'b1;
          ale_d   = 1'b1;
        end
      end
      bus_ctrl_pkg::S_ADDR: begin
        // strobe asserts as the bus clock falls
        state_d    = bus_ctrl_pkg::S_STROBE;
        ale_d      = 1'b0;
        ack_seen_d = 1'b0;
        rd_n_d     = req_write_i;
        wr_n_d     = !req_write_i;
        bwn_n_d    = !req_burst_i;
        den_n_d    = req_write_i;
        ad_oe_d    = req_write_i;
        ad_d       = req_write_i ? req_wdata_i : ad_q;
      end
      bus_ctrl_pkg::S_STROBE: begin
        // acknowledge is only looked at on the falling bus clock edge
        if (ack_s && fall_ev) begin
          ack_seen_d = 1'b1;
          rdata_d    = ad_i;
        end
        if (ack_seen_q && rise_ev) begin
          state_d = bus_ctrl_pkg::S_HOLD;
          rd_n_d  = 1'b1;
          wr_n_d  = 1'b1;
          bwn_n_d = 1'b1;
          den_n_d = 1'b1;
          done_d  = 1'b1;
        end
      end
      bus_ctrl_pkg::S_HOLD: begin
        // write data lingers one half bus clock; a read leaves the bus quiet as long
        ad_oe_d = 1'b0;
        // the synchronised acknowledge lags its pin, so leave only once it has
        // cleared, else the next cycle would take this cycle's stale one
        if (!ack_s) state_d = bus_ctrl_pkg::S_IDLE;
      end
      bus_ctrl_pkg::S_GRANT: begin
        if (!breq_s) begin
          state_d  = bus_ctrl_pkg::S_IDLE;
          gnt_n_d  = 1'b1;
          ctl_oe_d = 1'b1;
        end
      end
      default: begin
        state_d = bus_ctrl_pkg::S_IDLE;
      end
    endcase
    // tri-state mode overrides everything but the clock and aborts any cycle
    if (tri_s) begin
      state_d  = bus_ctrl_pkg::S_IDLE;
      ad_oe_d  = 1'b0;
      ctl_oe_d = 1'b0;
      gnt_oe_d = 1'b0;
      gnt_n_d  = 1'b1;
      ale_d    = 1'b0;
      rd_n_d   = 1'b1;
      wr_n_d   = 1'b1;
      bwn_n_d  = 1'b1;
      den_n_d  = 1'b1;
      done_d   = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= bus_ctrl_pkg::S_IDLE;
      system_clock_out_q   <= 1'b1;
      ack_seen_q <= 1'b0;
      ad_q       <= '0;
      ad_oe_q    <= 1'b0;
      ale_q      <= 1'b0;
      rd_n_q     <= 1'b1;
      wr_n_q     <= 1'b1;
      bwn_n_q    <= 1'b1;
      den_n_q    <= 1'b1;
      ctl_oe_q   <= 1'b1;
      gnt_n_q    <= 1'b1;
      gnt_oe_q   <= 1'b1;
      done_q     <= 1'b0;
      rdata_q    <= '0;
      stall_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      system_clock_out_q   <= system_clock_out_d;
      ack_seen_q <= ack_seen_d;
      ad_q       <= ad_d;
      ad_oe_q    <= ad_oe_d;
      ale_q      <= ale_d;
      rd_n_q     <= rd_n_d;
      wr_n_q     <= wr_n_d;
      bwn_n_q    <= bwn_n_d;
      den_n_q    <= den_n_d;
      ctl_oe_q   <= ctl_oe_d;
      gnt_n_q    <= gnt_n_d;
      gnt_oe_q   <= gnt_oe_d;
      done_q     <= done_d;
      rdata_q    <= rdata_d;
      stall_q    <= stall_d;
    end
  end

  // outputs straight from flip-flops
  assign system_clock_out_o      = system_clock_out_q;
  assign ad_o                    = ad_q;
  assign ad_oe_o                 = ad_oe_q;
  assign ale_o                   = ale_q;
  assign rd_n_o                  = rd_n_q;
  assign wr_n_o                  = wr_n_q;
  assign burst_or_near_write_n_o = bwn_n_q;
  assign data_drive_enable_n_o   = den_n_q;
  assign ctl_oe_o                = ctl_oe_q;
  assign bus_grant_n_o           = gnt_n_q;
  assign bus_grant_oe_o          = gnt_oe_q;
  assign done_o                  = done_q;
  assign rdata_o                 = rdata_q;
  assign core_stall_o            = stall_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  idle_float_a: assert property (state_q == bus_ctrl_pkg::S_IDLE && !tri_s |=>
    (state_q != bus_ctrl_pkg::S_IDLE) || (!ad_oe_o && ctl_oe_o && rd_n_o && wr_n_o))
    else $error("bus not floating with controls negated while idle");
  grant_reply_a: assert property (breq_s && !tri_s && state_q == bus_ctrl_pkg::S_IDLE
    && (system_clock_out_o || !req_valid_i) |-> ##[1:2] (!bus_grant_n_o || tri_s))
    else $error("bus request not granted within one bus clock");
  grant_float_a: assert property (!bus_grant_n_o |->
    !ad_oe_o && !ctl_oe_o && bus_grant_oe_o)
    else $error("something besides grant driven while bus is granted away");
  handover_quiet_a: assert property ($fell(bus_grant_n_o) |->
    $past(rd_n_o) && $past(wr_n_o) && $past(data_drive_enable_n_o) && !$past(ale_o))
    else $error("controls not at rest when bus handed over");
  tristate_all_a: assert property (tri_s |=>
    !ad_oe_o && !ctl_oe_o && !bus_grant_oe_o)
    else $error("output still driven in tri-state mode");
  strobe_edges_a: assert property (
    ($fell(rd_n_o) || $fell(wr_n_o)) |-> !system_clock_out_o)
    else $error("strobe asserted away from the falling bus clock edge");
  strobe_negate_a: assert property (
    ($rose(rd_n_o) || $rose(wr_n_o)) && ctl_oe_o |-> system_clock_out_o)
    else $error("strobe negated away from the rising bus clock edge");
  write_hold_a: assert property ($rose(wr_n_o) && ctl_oe_o |->
    ad_oe_o && ad_o == $past(ad_o) ##1 !ad_oe_o)
    else $error("write data not held for half a bus clock");
  read_release_a: assert property ($rose(rd_n_o) && ctl_oe_o |->
    !ad_oe_o [*2])
    else $error("address driven too soon after a read");
  core_stall_a: assert property (!bus_grant_n_o && req_valid_i && breq_s |=>
    core_stall_o || bus_grant_n_o)
    else $error("core not stalled on bus need while granted away");

  read_cycle_c:  cover property ($rose(rd_n_o) ##1 done_q == 1'b0);
  write_cycle_c: cover property ($fell(wr_n_o) ##[1:40] $rose(wr_n_o));
  grant_c:       cover property ($fell(bus_grant_n_o) ##[1:40] $rose(bus_grant_n_o));
  tristate_c:    cover property ($rose(tri_s));

endmodule // muxed_bus_transceiver_control

// ### test/mem_partner.sv
// memory bank model answering the bus controller's read and write cycles
`timescale 1ns/1ps
module mem_partner (
  input  wire logic                          clk_i,
  input  wire logic [bus_ctrl_pkg::AD_W-1:0] ad_o_i,
  input  wire logic                          ad_oe_i,
  input  wire logic                          ale_i,
  input  wire logic                          rd_n_i,
  input  wire logic                          wr_n_i,
  input  wire logic                          den_n_i,
  input  wire logic [3:0]                    wait_i,
  output logic      [bus_ctrl_pkg::AD_W-1:0] ad_bus_o,
  output logic                               ack_n_o
);
  logic [bus_ctrl_pkg::AD_W-1:0] mem_q [16];
  logic [bus_ctrl_pkg::AD_W-1:0] last_q   = 32'h0;
  logic [bus_ctrl_pkg::AD_W-1:0] lane_mask;
  logic [3:0]                    idx_q    = 4'h0;
  logic [3:0]                    be_q     = 4'h0;
  logic [3:0]                    cnt_q    = 4'h0;
  logic                          drive_q  = 1'b0;
  logic                          dir_rd_q = 1'b1;
  logic                          ack_q    = 1'b1;
  logic                          strobe;

  // -------------------------------------------------------------
  // bank behaviour, inputs taken on the rising clk edge, except the ad_oe_i pass-through of ad_o_i onto ad_bus_o
  // -------------------------------------------------------------
  assign strobe    = !rd_n_i || !wr_n_i;
  assign lane_mask = {{8{be_q[3]}}, {8{be_q[2]}}, {8{be_q[1]}}, {8{be_q[0]}}};
  always @(posedge clk_i) begin
    if (ale_i) begin
      idx_q <= ad_o_i[7:4];
      be_q  <= ad_o_i[3:0];
    end
    // wait states counted from the strobe, ack held until it negates
    if (!strobe) begin
      cnt_q <= 4'h0;
      ack_q <= 1'b1;
    end else if (cnt_q == wait_i) ack_q <= 1'b0;
    else cnt_q <= cnt_q + 4'h1;
    // only the selected byte lanes are written, the others keep their bytes
    if (!wr_n_i && !ack_q) begin
      mem_q[idx_q] <= (ad_o_i & lane_mask) | (mem_q[idx_q] & ~lane_mask);
    end
    // direction turns only while the read side is shut and holds between strobes, read at start
    if (!drive_q) dir_rd_q <= !wr_n_i ? 1'b0 : (!rd_n_i ? 1'b1 : dir_rd_q);
    drive_q <= !rd_n_i && !den_n_i && dir_rd_q;
    last_q  <= ad_bus_o;
  end
  assign ack_n_o = ack_q;
  // released lines show the inverse of the last value, not a held copy
  assign ad_bus_o = ad_oe_i ? ad_o_i : drive_q ? mem_q[idx_q] : ~last_q;
endmodule // mem_partner

// ### test/testbench.sv
// self-checking bench for the multiplexed bus controller
`timescale 1ns/1ps
module testbench;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        req_valid_i = 1'b0;
  logic        req_write_i = 1'b0;
  logic        req_burst_i = 1'b0;
  logic [31:0] req_addr_i = 32'h0;
  logic [3:0]  req_be_i = 4'h0;
  logic [31:0] req_wdata_i = 32'h0;
  logic        bus_request_n_i = 1'b1;
  logic        tristate_req_n_i = 1'b1;
  logic [3:0]  wait_cyc = 4'h0;
  logic [31:0] ad_i, ad_o, rdata_o;
  logic        done_o, core_stall_o, ad_oe_o, ale_o, rd_n_o, wr_n_o, burst_n_o, den_n_o;
  logic        ctl_oe_o, ack_n_i, bus_grant_n_o, bus_grant_oe_o, system_clock_out_o;
  logic        rd_w, wr_w, den_w, burst_w, ale_w;
  int          fail_count = 0;
  int          checks_done = 0;

  // -------------------------------------------------------------
  // clock, pin resolution with the pull-ups and the latch pull-down
  // -------------------------------------------------------------
  always #2 clk_i = ~clk_i;
  assign rd_w    = ctl_oe_o ? rd_n_o : 1'b1;
  assign wr_w    = ctl_oe_o ? wr_n_o : 1'b1;
  assign den_w   = ctl_oe_o ? den_n_o : 1'b1;
  assign burst_w = ctl_oe_o ? burst_n_o : 1'b1;
  assign ale_w   = ctl_oe_o ? ale_o : 1'b0;

  muxed_bus_transceiver_control muxed_bus_transceiver_control_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_burst_i(req_burst_i), .req_addr_i(req_addr_i),
    .req_be_i(req_be_i), .req_wdata_i(req_wdata_i), .done_o(done_o), .rdata_o(rdata_o),
    .core_stall_o(core_stall_o), .ad_i(ad_i), .ad_o(ad_o), .ad_oe_o(ad_oe_o),
    .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .burst_or_near_write_n_o(burst_n_o),
    .data_drive_enable_n_o(den_n_o), .ctl_oe_o(ctl_oe_o), .ack_n_i(ack_n_i),
    .bus_request_n_i(bus_request_n_i), .bus_grant_n_o(bus_grant_n_o),
    .bus_grant_oe_o(bus_grant_oe_o), .tristate_req_n_i(tristate_req_n_i),
    .system_clock_out_o(system_clock_out_o));

  mem_partner mem_partner_i (
    .clk_i(clk_i), .ad_o_i(ad_o), .ad_oe_i(ad_oe_o), .ale_i(ale_w), .rd_n_i(rd_w),
    .wr_n_i(wr_w), .den_n_i(den_w), .wait_i(wait_cyc), .ad_bus_o(ad_i), .ack_n_o(ack_n_i));

  // -------------------------------------------------------------
  // shared helpers
  // -------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // one core cycle, judged at every edge until done and one after
  task automatic do_cycle(input logic wr, input logic bst, input logic [31:0] a,
                          input logic [3:0] be, input logic [31:0] d);
    int n;
    n = 0;
    tick(1);
    {req_valid_i, req_write_i, req_burst_i} = {1'b1, wr, bst};
    {req_addr_i, req_be_i, req_wdata_i} = {a, be, d};
    while (done_o !== 1'b1 && n < 300) begin
      tick(1);
      n++;
      if (ale_o === 1'b1) check(ad_o, a | {28'h0, be});
      if (rd_n_o === 1'b0) check({ad_oe_o, den_n_o}, 2'b00);
      if (rd_n_o === 1'b0 || wr_n_o === 1'b0) check(burst_n_o, {31'h0, ~bst});
    end
    req_valid_i = 1'b0;
    if (n >= 300) check(1'b0, 1'b1);
    check({rd_n_o, wr_n_o, den_n_o}, 3'h7);
    if (wr) begin
      check(ad_o, d);
      check(ad_oe_o, 1'b1);
    end else begin
      check(rdata_o, d);
    end
    tick(1);
    check({ad_oe_o, ale_o, ctl_oe_o, rd_n_o, wr_n_o}, 5'h07);
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic sc_reset_state();
    check({ad_oe_o, ale_o, rd_n_o, wr_n_o, den_n_o, ctl_oe_o}, 6'h0f);
    check({bus_grant_n_o, bus_grant_oe_o, done_o}, 3'h6);
  endtask

  // slow and fast writes, reads, a write straight after a read, a burst
  task automatic sc_traffic();
    wait_cyc = 4'h0;
    do_cycle(1'b1, 1'b0, 32'h0000_0010, 4'hf, 32'h1234_5678);
    do_cycle(1'b1, 1'b1, 32'h0000_0020, 4'hf, 32'hffff_ffff);
    do_cycle(1'b1, 1'b0, 32'h0000_0030, 4'hf, 32'hffff_ffff);
    wait_cyc = 4'h3;
    do_cycle(1'b1, 1'b0, 32'h0000_0020, 4'h3, 32'hcafe_0042);
    do_cycle(1'b0, 1'b0, 32'h0000_0010, 4'hf, 32'h1234_5678);
    wait_cyc = 4'h0;
    do_cycle(1'b1, 1'b0, 32'h0000_0030, 4'h1, 32'h0bad_f00d);
    // partial writes only replaced their own byte lanes
    do_cycle(1'b0, 1'b1, 32'h0000_0020, 4'hf, 32'hffff_0042);
    do_cycle(1'b0, 1'b0, 32'h0000_0030, 4'hf, 32'hffff_ff0d);
  endtask

  // handover to an outside master with a core request left waiting
  task automatic sc_grant();
    int n;
    n = 0;
    bus_request_n_i = 1'b0;
    while (bus_grant_n_o !== 1'b0 && n < 40) begin
      tick(1);
      n++;
    end
    check({bus_grant_oe_o, bus_grant_n_o, ctl_oe_o, ad_oe_o}, 4'h8);
    check({rd_w, wr_w, den_w, burst_w, ale_w}, 5'h1e);
    {req_valid_i, req_write_i, req_addr_i} = {1'b1, 1'b0, 32'h0000_0010};
    tick(6);
    check({core_stall_o, ctl_oe_o, bus_grant_n_o}, 3'h4);
    bus_request_n_i = 1'b1;
    do_cycle(1'b0, 1'b0, 32'h0000_0010, 4'hf, 32'h1234_5678);
    check({bus_grant_n_o, bus_grant_oe_o, core_stall_o}, 3'h6);
  endtask

  // tri-state mode floats every output but the system clock
  task automatic sc_tristate();
    logic ck;
    tristate_req_n_i = 1'b0;
    tick(10);
    check({ad_oe_o, ctl_oe_o, bus_grant_oe_o}, 3'h0);
    ck = system_clock_out_o;
    tick(1);
    check(system_clock_out_o, {31'h0, ~ck});
    tristate_req_n_i = 1'b1;
    tick(10);
    check({ctl_oe_o, bus_grant_oe_o, ad_oe_o}, 3'h6);
  endtask

  // -------------------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    tick(16);
    arst_n_i = 1'b1;
    tick(10);
    sc_reset_state();
    sc_traffic();
    sc_grant();
    sc_tristate();
    final_report();
  end

  // the full run needs a few hundred cycles, far below this span
  initial begin
    #100us;
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end
endmodule // testbench
